// file: bench/hbc_winding_model.sv
// hbc_winding_model: bridge transistors, winding current and flag pull-up
`timescale 1ns/1ps
module hbc_winding_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire hbc_pkg::hbc_bridge_type bridge_i,
    input wire logic [15:0] thr_i,
    input wire logic flag_i,
    input wire logic flag_oe_i,
    output logic sense_threshold_o,
    output logic flag_pin_o
);
    import hbc_pkg::*;
    int cur = 0;
    int drv;
    logic [1:0] slow_cnt = 2'h0;
    // ------------------------------------------------------------
    // flag pin and comparator
    // ------------------------------------------------------------
    // external pull-up
    assign flag_pin_o = flag_oe_i ? flag_i : 1'b1;
    assign sense_threshold_o = (cur >= int'(thr_i)) || (-cur >= int'(thr_i));
    // ------------------------------------------------------------
    // winding current
    // ------------------------------------------------------------
    // signed current: a diagonal pair either pushes it or drains it to zero
    assign drv = (bridge_i == 4'h9) ? 1 : (bridge_i == 4'h6) ? -1 : 0;
    always @(posedge clk_i) begin
        slow_cnt <= slow_cnt + 2'h1;
        if (rst_i) begin
            cur <= 0;
        end else if (drv != 0 && (cur == 0 || (cur > 0) == (drv > 0))) begin
            cur <= cur + 2 * drv;
        end else if (drv != 0) begin
            cur <= (cur > 2) ? cur - 2 : (cur < -2) ? cur + 2 : 0;
        end else if (bridge_i == 4'h3 && slow_cnt != 2'h0) begin
            cur <= cur;
        end else begin
            cur <= (cur > 0) ? cur - 1 : (cur < 0) ? cur + 1 : 0;
        end
    end
endmodule

// file: bench/testbench.sv
// testbench: scenarios for the bridge chopper control
`timescale 1ns/1ps
module testbench;
    import hbc_pkg::*;
    // default divider gives 100 kHz; 4 keeps the run short
    localparam int unsigned TB_DIV = 4;
    localparam int P = 16 * TB_DIV;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic therm = 1'b0;
    logic ocur = 1'b0;
    logic [1:0] mode = DECAY_SLOW;
    logic fwd = 1'b1;
    logic stby = 1'b0;
    logic [15:0] thr = 16'h0008;
    logic sense;
    logic flag;
    logic flag_oe;
    logic pin;
    hbc_bridge_type br;
    int failures = 0;
    int n_compared = 0;
    int zrun = 0;
    logic [3:0] last_nz = 4'h0;

    hbc_ctrl #(.OSC_DIV(TB_DIV)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .thermal_shutdown_i(therm), .overcurrent_shutdown_i(ocur), .sense_threshold_i(sense),
        .decay_mode_i(mode), .dir_fwd_i(fwd), .standby_i(stby), .bridge_o(br),
        .error_flag_out_o(flag), .error_flag_out_oe_o(flag_oe));
    hbc_winding_model u_wind (.clk_i(clk_i), .rst_i(rst_i), .bridge_i(br), .thr_i(thr),
        .flag_i(flag), .flag_oe_i(flag_oe), .sense_threshold_o(sense), .flag_pin_o(pin));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic c);
        chk(nm, 4'h1, {3'h0, c});
    endtask

    // waits until (br == t) equals want, bounded by lim cycles
    task automatic wait_br(input logic [3:0] t, input int lim, input logic want, output int n);
        n = 0;
        while (((br === t) != want) && n < lim) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // from a charge entry to the next: first and last decay pattern, length
    task automatic one_period(output logic [3:0] d0, output logic [3:0] d1, output int len);
        logic [3:0] c;
        int n;
        c = br;
        wait_br(c, 4 * P, 1'b0, len);
        wait_br(4'h0, P, 1'b0, n);
        len += n;
        d0 = br;
        d1 = br;
        while (br !== c && n < 4 * P) begin
            if (br !== 4'h0) d1 = br;
            @(negedge clk_i);
            n++;
            len++;
        end
    endtask

    always @(negedge clk_i) begin
        if (!rst_i) begin
            if ((br.upper_switch_one && br.lower_switch_one) ||
                (br.upper_switch_two && br.lower_switch_two)) chk("leg_overlap", 4'h0, br);
            if (br === BRIDGE_OFF) begin
                zrun <= zrun + 1;
            end else begin
                if (br !== last_nz && last_nz !== 4'h0 && zrun < int'(DEAD_CYC))
                    chk("dead_gap", 4'h0, br);
                last_nz <= br;
                zrun <= 0;
            end
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int n;
        chk("bridge_rst", 4'h0, br);
        chkb("pin_rst", pin);
        wait_br(4'h9, 2 * P, 1'b1, n);
        chkb("first_charge", n >= P && n <= P + int'(DEAD_CYC) + 4);
        $display("test reset done");
    endtask

    task automatic t_period();
        logic [3:0] d0, d1;
        int len;
        one_period(d0, d1, len);
        chk("slow_decay", 4'h3, d0);
        chkb("period_len", len == P);
        $display("test period done");
    endtask

    task automatic t_modes();
        logic [3:0] d0, d1, ch, fa;
        int len;
        int n;
        for (int k = 0; k < 8; k++) begin
            @(negedge clk_i);
            fwd = ~k[2];
            mode = k[1:0];
            ch = fwd ? 4'h9 : 4'h6;
            fa = fwd ? 4'h6 : 4'h9;
            wait_br(ch, 4 * P, 1'b0, n);
            wait_br(ch, 4 * P, 1'b1, n);
            chk("charge_dir", ch, br);
            one_period(d0, d1, len);
            chk("decay_first", (mode == DECAY_SLOW || mode == DECAY_MIXED) ? 4'h3 : fa, d0);
            chk("decay_last", (mode == DECAY_SLOW) ? 4'h3 : fa, d1);
            chkb("mode_period", len == P);
        end
        $display("test modes done");
    endtask

    task automatic t_extended();
        int n;
        @(negedge clk_i);
        fwd = 1'b1;
        mode = DECAY_SLOW;
        thr = 16'hFFFF;
        wait_br(4'h9, 4 * P, 1'b0, n);
        wait_br(4'h9, 4 * P, 1'b1, n);
        wait_br(4'h9, 3 * P, 1'b0, n);
        chkb("charge_held", n == 3 * P);
        thr = 16'h0008;
        wait_br(4'h9, 8, 1'b0, n);
        chkb("charge_end", n <= 5);
        wait_br(4'h0, P, 1'b0, n);
        chk("decay_after", 4'h3, br);
        $display("test extended done");
    endtask

    task automatic t_fault(input logic over);
        int n;
        logic on;
        @(negedge clk_i);
        therm = !over;
        ocur = over;
        repeat (3) @(negedge clk_i);
        chkb("flag_low", !pin);
        @(negedge clk_i);
        chk("bridge_off", 4'h0, br);
        on = 1'b0;
        repeat (2 * P) begin
            @(negedge clk_i);
            on |= (br !== 4'h0);
        end
        chkb("held_off", !on);
        stby = 1'b1;
        @(negedge clk_i);
        stby = 1'b0;
        repeat (4) @(negedge clk_i);
        chkb("clear_refused", !pin);
        therm = 1'b0;
        ocur = 1'b0;
        repeat (6) @(negedge clk_i);
        chkb("fault_latched", !pin);
        stby = 1'b1;
        @(negedge clk_i);
        stby = 1'b0;
        repeat (4) @(negedge clk_i);
        chkb("flag_released", pin);
        wait_br(4'h9, 2 * P, 1'b1, n);
        chkb("restart", n < 2 * P);
        $display("test fault done");
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("BAD watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_period();
        t_modes();
        t_extended();
        t_fault(1'b0);
        t_fault(1'b1);
        finish_test();
    end
endmodule

// file: rtl/hbc_chop_div.sv
// hbc_chop_div: chop oscillator tick and chopping period divider
`timescale 1ns/1ps
module hbc_chop_div #(
    parameter int unsigned OSC_DIV = hbc_pkg::OSC_DIV,
    parameter int unsigned CHOP_DIV = hbc_pkg::CHOP_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic osc_tick_o,
    output logic chop_start_o,
    output logic [hbc_pkg::PHASE_W-1:0] phase_o
);
    import hbc_pkg::*;

    logic [11:0] pre_r, pre_nxt;
    logic [PHASE_W-1:0] phase_r, phase_nxt;
    logic tick;

    always_comb begin
        tick = (pre_r == 12'(OSC_DIV - 1));
        pre_nxt = tick ? 12'h000 : pre_r + 12'h001;
        phase_nxt = phase_r;
        if (tick) begin
            phase_nxt = (phase_r == PHASE_W'(CHOP_DIV - 1)) ? '0 : phase_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_r <= 12'h000;
            phase_r <= '0;
        end else begin
            pre_r <= pre_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign osc_tick_o = tick;
    // period start: oscillator divided by sixteen
    assign chop_start_o = tick && (phase_r == PHASE_W'(CHOP_DIV - 1));
    assign phase_o = phase_r;
endmodule

// file: rtl/hbc_ctrl.sv
// hbc_ctrl: charge/slow/fast chopping control of one winding bridge
`timescale 1ns/1ps
module hbc_ctrl #(
    parameter int unsigned OSC_DIV = hbc_pkg::OSC_DIV
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic thermal_shutdown_i,
    input wire logic overcurrent_shutdown_i,
    input wire logic sense_threshold_i,
    input wire logic [1:0] decay_mode_i,
    input wire logic dir_fwd_i,
    input wire logic standby_i,
    output hbc_pkg::hbc_bridge_type bridge_o,
    output logic error_flag_out_o,
    output logic error_flag_out_oe_o
);
    import hbc_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_meta_r, pin_sync_r;
    logic therm_s, ocur_s, sense_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {thermal_shutdown_i, overcurrent_shutdown_i, sense_threshold_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign therm_s = pin_sync_r[2];
    assign ocur_s = pin_sync_r[1];
    assign sense_s = pin_sync_r[0];

    // ------------------------------------------------------------
    // chopping period
    // ------------------------------------------------------------
    logic osc_tick, chop_start;
    logic [PHASE_W-1:0] phase;

    hbc_chop_div #(
        .OSC_DIV(OSC_DIV),
        .CHOP_DIV(CHOP_DIV)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .osc_tick_o(osc_tick),
        .chop_start_o(chop_start),
        .phase_o(phase)
    );

    // ------------------------------------------------------------
    // fault latch
    // ------------------------------------------------------------
    logic fault_r, fault_nxt;

    always_comb begin
        // cleared only by standby; a new detection wins
        fault_nxt = therm_s || ocur_s || (fault_r && !standby_i);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    assign error_flag_out_o = 1'b0;
    assign error_flag_out_oe_o = fault_r;

    // ------------------------------------------------------------
    // bridge state machine
    // ------------------------------------------------------------
    hbc_state_type st_r, st_nxt, tgt_r, tgt_nxt;
    logic [DEAD_W-1:0] dcnt_r, dcnt_nxt;
    logic dir_r, dir_nxt;
    hbc_bridge_type bridge_r, bridge_nxt;
    logic run;

    // decay state chosen by mode when charge ends
    function automatic hbc_state_type decay_pick(input logic [1:0] mode,
                                                 input logic [PHASE_W-1:0] ph);
        hbc_state_type s;
        unique case (mode)
            DECAY_SLOW: s = ST_SLOW;
            DECAY_FAST: s = ST_FAST;
            // falling target shows as charge ending early; fast follows it
            DECAY_AUTO: s = (ph < AUTO_SPLIT_PHASE) ? ST_FAST : ST_SLOW;
            DECAY_MIXED: s = (ph >= MIX_FAST_PHASE) ? ST_FAST : ST_SLOW;
        endcase
        return s;
    endfunction

    // switch pattern per state and direction
    function automatic hbc_bridge_type drive(input hbc_state_type s, input logic fwd);
        hbc_bridge_type b;
        b = BRIDGE_OFF;
        unique case (s)
            ST_CHARGE: begin
                b.upper_switch_one = fwd;
                b.lower_switch_two = fwd;
                b.upper_switch_two = !fwd;
                b.lower_switch_one = !fwd;
            end
            ST_FAST: begin
                b.upper_switch_two = fwd;
                b.lower_switch_one = fwd;
                b.upper_switch_one = !fwd;
                b.lower_switch_two = !fwd;
            end
            ST_SLOW: begin
                b.lower_switch_one = 1'b1;
                b.lower_switch_two = 1'b1;
            end
            ST_OFF, ST_DEAD: b = BRIDGE_OFF;
        endcase
        return b;
    endfunction

    assign run = !fault_r && !standby_i;

    always_comb begin
        st_nxt = st_r;
        tgt_nxt = tgt_r;
        dcnt_nxt = dcnt_r;
        unique case (st_r)
            ST_OFF: begin
                if (chop_start) begin
                    st_nxt = ST_DEAD;
                    tgt_nxt = ST_CHARGE;
                    dcnt_nxt = DEAD_W'(DEAD_CYC - 1);
                end
            end
            // all switches off before any new state
            ST_DEAD: begin
                if (chop_start) begin
                    tgt_nxt = ST_CHARGE;
                end
                if (dcnt_r == '0) begin
                    st_nxt = chop_start ? ST_CHARGE : tgt_r;
                end else begin
                    dcnt_nxt = dcnt_r - 1'b1;
                end
            end
            // boundary ignored until threshold; then decay
            ST_CHARGE: begin
                if (sense_s) begin
                    st_nxt = ST_DEAD;
                    tgt_nxt = decay_pick(decay_mode_i, phase);
                    dcnt_nxt = DEAD_W'(DEAD_CYC - 1);
                end
            end
            ST_SLOW: begin
                if (chop_start) begin
                    st_nxt = ST_DEAD;
                    tgt_nxt = ST_CHARGE;
                    dcnt_nxt = DEAD_W'(DEAD_CYC - 1);
                end else if (decay_mode_i == DECAY_MIXED && phase >= MIX_FAST_PHASE) begin
                    st_nxt = ST_DEAD;
                    tgt_nxt = ST_FAST;
                    dcnt_nxt = DEAD_W'(DEAD_CYC - 1);
                end
            end
            ST_FAST: begin
                if (chop_start) begin
                    st_nxt = ST_DEAD;
                    tgt_nxt = ST_CHARGE;
                    dcnt_nxt = DEAD_W'(DEAD_CYC - 1);
                end
            end
        endcase
        // fault or standby forces the bridge off
        if (!run) begin
            st_nxt = ST_OFF;
            tgt_nxt = ST_CHARGE;
            dcnt_nxt = '0;
        end
        // direction only changes while the bridge is dark
        dir_nxt = (st_r == ST_OFF || st_r == ST_DEAD) ? dir_fwd_i : dir_r;
        bridge_nxt = drive(st_nxt, dir_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= ST_OFF;
            tgt_r <= ST_CHARGE;
            dcnt_r <= '0;
            dir_r <= 1'b1;
            bridge_r <= BRIDGE_OFF;
        end else begin
            st_r <= st_nxt;
            tgt_r <= tgt_nxt;
            dcnt_r <= dcnt_nxt;
            dir_r <= dir_nxt;
            bridge_r <= bridge_nxt;
        end
    end

    assign bridge_o = bridge_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] tick_cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i || chop_start) begin
            tick_cnt_r <= '0;
        end else if (osc_tick) begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
        end
    end

    property p_flag_fault;
        @(posedge clk_i) disable iff (rst_i)
        (therm_s || ocur_s) |=> (error_flag_out_oe_o && !error_flag_out_o);
    endproperty
    a_flag_fault: assert property (p_flag_fault) else $error("flag not low on fault");

    property p_flag_idle;
        @(posedge clk_i) disable iff (rst_i)
        (!therm_s && !ocur_s && standby_i) |=> !error_flag_out_oe_o;
    endproperty
    a_flag_idle: assert property (p_flag_idle) else $error("flag held without fault");

    property p_ext_charge;
        @(posedge clk_i) disable iff (rst_i)
        (st_r == ST_CHARGE && chop_start && !sense_s && run && !therm_s && !ocur_s)
            |=> (st_r == ST_CHARGE);
    endproperty
    a_ext_charge: assert property (p_ext_charge) else $error("charge cut at boundary");

    property p_charge_end;
        @(posedge clk_i) disable iff (rst_i)
        (st_r == ST_CHARGE && sense_s) |=> (st_r != ST_CHARGE) ##[1:12] (st_r != ST_DEAD);
    endproperty
    a_charge_end: assert property (p_charge_end) else $error("charge not ended");

    property p_fwd;
        @(posedge clk_i) disable iff (rst_i)
        (st_r == ST_CHARGE && dir_r) |-> (bridge_o == 4'h9);
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward charge pattern wrong");

    property p_rev;
        @(posedge clk_i) disable iff (rst_i)
        (st_r == ST_FAST && !dir_r) |-> (bridge_o == 4'h9);
    endproperty
    a_rev: assert property (p_rev) else $error("reverse fast pattern wrong");

    property p_slow;
        @(posedge clk_i) disable iff (rst_i)
        (st_r == ST_SLOW) |-> (bridge_o == 4'h3);
    endproperty
    a_slow: assert property (p_slow) else $error("slow decay pattern wrong");

    property p_period;
        @(posedge clk_i) disable iff (rst_i)
        (chop_start && $past(chop_start, 2) == 1'b0) |-> (tick_cnt_r == 4'hF) && osc_tick;
    endproperty
    a_period: assert property (p_period) else $error("chop period not sixteen ticks");

    property p_mode_slow;
        @(posedge clk_i) disable iff (rst_i)
        (decay_mode_i == DECAY_SLOW && st_r == ST_CHARGE && sense_s && run)
            |=> (tgt_r == ST_SLOW);
    endproperty
    a_mode_slow: assert property (p_mode_slow) else $error("slow only mode broken");

    property p_fault_off;
        @(posedge clk_i) disable iff (rst_i)
        fault_r |=> (bridge_o == BRIDGE_OFF);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("bridge on under fault");

    property p_leg_safe;
        @(posedge clk_i) disable iff (rst_i)
        !(bridge_o.upper_switch_one && bridge_o.lower_switch_one)
            && !(bridge_o.upper_switch_two && bridge_o.lower_switch_two);
    endproperty
    a_leg_safe: assert property (p_leg_safe) else $error("leg shoot-through");

    property p_dead_gap;
        @(posedge clk_i) disable iff (rst_i)
        ($changed(bridge_o) && bridge_o != BRIDGE_OFF) |-> ($past(bridge_o) == BRIDGE_OFF);
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("no dead interval");
endmodule

// file: shared/hbc_pkg.sv
// hbc_pkg: constants and types shared by the bridge chopper control
package hbc_pkg;
    // ------------------------------------------------------------
    // clock and chopping timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned CHOP_OSC_KHZ = 1600;
    // system clock cycles per chop oscillator tick
    localparam int unsigned OSC_DIV = (CLK_MHZ * 1000) / CHOP_OSC_KHZ;
    // oscillator ticks per chopping period
    localparam int unsigned CHOP_DIV = 16;
    localparam int unsigned PHASE_W = 4;
    // dead interval between bridge states, least time, rounded up
    localparam int unsigned DEAD_NS = 50;
    localparam int unsigned CLK_PERIOD_PS = 1000000 / CLK_MHZ;
    localparam int unsigned DEAD_CYC = (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DEAD_W = 8;
    // mixed decay: fast decay from this phase to period end
    localparam logic [PHASE_W-1:0] MIX_FAST_PHASE = 4'hA;
    // auto decay: charge ending before this phase means current is falling
    localparam logic [PHASE_W-1:0] AUTO_SPLIT_PHASE = 4'h8;

    // ------------------------------------------------------------
    // decay mode field
    // ------------------------------------------------------------
    localparam logic [1:0] DECAY_MIXED = 2'h0;
    localparam logic [1:0] DECAY_SLOW = 2'h1;
    localparam logic [1:0] DECAY_FAST = 2'h2;
    localparam logic [1:0] DECAY_AUTO = 2'h3;
    localparam logic [1:0] DECAY_RESET = DECAY_MIXED;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_DEAD,
        ST_CHARGE,
        ST_SLOW,
        ST_FAST
    } hbc_state_type;

    typedef struct packed {
        logic upper_switch_one;
        logic upper_switch_two;
        logic lower_switch_one;
        logic lower_switch_two;
    } hbc_bridge_type;

    localparam hbc_bridge_type BRIDGE_OFF = 4'h0;
endpackage
